// ---- verif/pbdsc_xport.sv ----
// Purpose: Transport stand-in that feeds the device lines of the core
// Assumes: Characters flow only while the core runs an operation
// Notes:   Strobe is slow enough for the two-flop synchroniser
`timescale 1ns/1ps
module pbdsc_xport (
  // Clock and run level
  input  wire logic             clk,
  input  wire logic             op_run,
  // Conditions set by the bench
  input  wire logic             wprot,
  input  wire logic             bot,
  input  wire logic             bad,
  // Device lines
  output pbdsc_pkg::pbdsc_dev_t dev
);
  import pbdsc_pkg::*;
  logic [2:0] cnt_r;
  // One character per eight cycles, none while idle
  always_ff @(posedge clk) begin
    cnt_r <= op_run ? cnt_r + 3'h1 : 3'h0;
  end
  // Protect and tape-start levels make write and reverse-space starts illegal
  assign dev = '{wprot: wprot, bot: bot, char_stb: cnt_r[2], par_bad: bad};
endmodule : pbdsc_xport

// ---- verif/peripheral_busy_done_status_ctrl_test.sv ----
// Purpose: Self-checking bench for the busy/done status core
// Assumes: Small character counts keep the run short
// Notes:   Expectations come from the flag rules, never from outputs
`timescale 1ns/1ps
module peripheral_busy_done_status_ctrl_test;
  import pbdsc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, flag_stb = 1'b0, ctrl_wr = 1'b0;
  logic wprot = 1'b0, bot = 1'b0, bad = 1'b0;
  logic [1:0] flag_code = FC_NONE, test_code = TF_BUSY_SET;
  logic [WORD_W-1:0] ctrl_word = WORD_ZERO, status_word;
  logic skip_true, busy, done, int_req, pulse_out, op_run;
  logic [2:0] unit_sel, op_sel;
  pbdsc_dev_t dev_in;
  int err_total = 0, checked = 0;
  // Free-running system clock
  always #50 clk = ~clk;
  pbdsc_core dut (.clk, .rst, .flag_stb, .flag_code, .ctrl_wr, .ctrl_word, .test_code, .skip_true,
    .status_word, .busy, .done, .int_req, .pulse_out, .dev_in, .unit_sel, .op_sel, .op_run);
  pbdsc_xport xp (.clk, .op_run, .wprot, .bot, .bad, .dev(dev_in));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  function automatic logic [15:0] cw(logic [2:0] u, logic [2:0] op, logic [7:0] n);
    return {n, 2'h0, op, u};
  endfunction : cw
  // One instruction; flag and word taken at the second edge
  task automatic cmd(input logic [1:0] fc, input logic wr, input logic [15:0] w);
    @(posedge clk);
    flag_stb <= (fc != FC_NONE);
    flag_code <= fc;
    ctrl_wr <= wr;
    ctrl_word <= w;
    @(posedge clk);
    flag_stb <= 1'b0;
    ctrl_wr <= 1'b0;
    #1;
  endtask : cmd
  // Flag levels plus every skip code; call only while flags are steady
  task automatic flags(input logic eb, input logic ed);
    logic [3:0] e;
    e = {~ed, ed, ~eb, eb};
    chk({12'h0, busy, done, int_req, op_run}, {12'h0, eb, ed, ed, eb});
    for (int t = 0; t < 4; t++) begin
      @(posedge clk);
      test_code <= 2'(t);
      #1;
      chk(16'(skip_true), 16'(e[t]));
    end
  endtask : flags
  // Bounded wait; busy must hold until done shows
  task automatic wait_done;
    for (int i = 0; i < 300; i++) begin
      @(posedge clk);
      #1;
      if (done === 1'b1) return;
      chk(16'(busy), 16'h1);
    end
    err_total++;
    $display("MISMATCH t=%0t no completion", $time);
    tally_and_finish;
  endtask : wait_done
  task automatic t_read;
    bad <= 1'b1;
    cmd(FC_START, 1'b1, cw(3'h5, OP_READ, 8'h02));
    flags(1'b1, 1'b0);
    chk(status_word & 16'h0ff7, 16'h0025);
    chk({10'h0, unit_sel, op_sel}, {10'h0, 3'h5, OP_READ});
    wait_done();
    flags(1'b0, 1'b1);
    chk(status_word & 16'hc000, 16'h8000);
    $display("test read done");
  endtask : t_read
  task automatic t_restart;
    bad <= 1'b0;
    cmd(FC_START, 1'b1, cw(3'h2, OP_SPFWD, 8'h01));
    @(posedge clk);
    #1;
    chk(status_word & 16'hc000, 16'h0000);
    wait_done();
    flags(1'b0, 1'b1);
    $display("test restart done");
  endtask : t_restart
  task automatic t_clear;
    cmd(FC_START, 1'b1, cw(3'h1, OP_READ, 8'h03));
    cmd(FC_CLEAR, 1'b0, WORD_ZERO);
    flags(1'b0, 1'b0);
    repeat (40) @(posedge clk);
    #1;
    flags(1'b0, 1'b0);
    $display("test clear done");
  endtask : t_clear
  task automatic t_illegal;
    for (int k = 0; k < 2; k++) begin
      cmd(FC_CLEAR, 1'b0, WORD_ZERO);
      wprot <= (k == 0);
      bot <= (k == 1);
      repeat (4) @(posedge clk);
      cmd(FC_START, 1'b1, cw(3'h0, k ? OP_SPREV : OP_WRITE, 8'h04));
      flags(1'b0, 1'b1);
      chk(status_word & 16'hf000, k ? 16'h5000 : 16'h6000);
    end
    $display("test illegal done");
  endtask : t_illegal
  task automatic t_pulse;
    int n;
    cmd(FC_PULSE, 1'b0, WORD_ZERO);
    n = int'(pulse_out);
    repeat (3) begin
      @(posedge clk);
      #1;
      n += int'(pulse_out);
    end
    chk(16'(n), 16'h1);
    flags(1'b0, 1'b1);
    $display("test pulse done");
  endtask : t_pulse
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    flags(1'b0, 1'b0);
    $display("test reset done");
    t_read();
    t_restart();
    t_clear();
    t_illegal();
    t_pulse();
    tally_and_finish();
  end
endmodule : peripheral_busy_done_status_ctrl_test

// ---- verilog/pbdsc_core.sv ----
// Purpose: Busy/done state, status word and control latch of a programmed-I/O peripheral
// Assumes: Instruction decode is outside; one strobe per I/O instruction
// Notes:   Device lines from the transport are asynchronous and are synchronised here
//
// Functional notes
// RL1: Setting busy to one starts a peripheral operation.
// RL2: Busy stays high for the whole operation.
// RL3: On completion busy clears and done sets.
// RL4: Interrupt request follows done; never requested while done is zero.
// RL5: Clearing done and setting busy is accepted as a new start.
// RL6: Clearing both flags idles the peripheral, which then stays inactive.
// RL7: Busy and done are testable directly; other flags only via status read.
// RL8: Each extra status flag has a fixed bit in the 16-bit status word.
// RL9: Passive errors set a flag silently; the operation still completes normally.
// RL10: Disallowed start sets active error, skips the operation, sets done at once.
// RL11: Bad parity character sets parity error while the read continues.
// RL12: Illegal request sets done and illegal flag together.
// RL13: Illegal means write when protected or reverse space at beginning of tape.
// RL14: Three-bit field at bus bits 13-15 selects one of eight transports.
// RL15: Control word written by program reads back as changed status.
// RL16: Changing parameters such as remaining count are readable mid-operation.
// RL17: Control parameters come from accumulator fields of an output transfer and latch.
// RL18: Data buffer under data channel needs no programmed I/O access.
// RL19: Flag code 01 starts: busy to one, done to zero.
// RL20: Flag code 10 clears: busy and done to zero.
// RL21: Flag code 11 is a peripheral-specific pulse.
// RL22: Skip test codes 00-11 select busy set, busy clear, done set, done clear.
// RL23: Error flags are cleared when a new operation starts.
`timescale 1ns/1ps
module pbdsc_core (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // Flag control from the instruction decoder
  input  wire logic                        flag_stb,
  input  wire logic [1:0]                  flag_code,
  // Control parameter output transfer
  input  wire logic                        ctrl_wr,
  input  wire logic [pbdsc_pkg::WORD_W-1:0] ctrl_word,
  // Skip test
  input  wire logic [1:0]                  test_code,
  output logic                             skip_true,
  // Status read
  output logic [pbdsc_pkg::WORD_W-1:0]     status_word,
  // Flags and interrupt
  output logic                             busy,
  output logic                             done,
  output logic                             int_req,
  output logic                             pulse_out,
  // Attached device
  input  wire pbdsc_pkg::pbdsc_dev_t       dev_in,
  output logic [2:0]                       unit_sel,
  output logic [2:0]                       op_sel,
  output logic                             op_run
);
  import pbdsc_pkg::*;

  typedef enum logic [1:0] {
    PBDSC_IDLE = 2'b00,
    PBDSC_RUN  = 2'b01,
    PBDSC_DONE = 2'b10
  } pbdsc_state_t;

  pbdsc_state_t state_r, state_nxt;
  pbdsc_ctrl_t  ctrl_r, ctrl_nxt, ctrl_nxt_r;
  pbdsc_dev_t   dev_s1_r, dev_s2_r;
  logic         stb_d_r;
  logic         par_err_r, ill_r, par_err_nxt, ill_nxt;
  logic         pulse_r;
  logic [WORD_W-1:0] status_r;

  // Two-flop synchroniser for the transport's asynchronous lines
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dev_s1_r <= '0;
      dev_s2_r <= '0;
      stb_d_r  <= 1'b0;
    end else begin
      dev_s1_r <= dev_in;
      dev_s2_r <= dev_s1_r;
      stb_d_r  <= dev_s2_r.char_stb;
    end
  end

  // Flag field decode, shared by the command wires and the assertion sequences
  function automatic logic flag_is(input logic stb, input logic [1:0] code, input logic [1:0] want);
    return stb && (code == want);
  endfunction : flag_is

  // Decode of the flag field and the device events
  wire start_cmd = flag_is(flag_stb, flag_code, FC_START);  // see RL19
  wire clear_cmd = flag_is(flag_stb, flag_code, FC_CLEAR);  // see RL20
  wire pulse_cmd = flag_is(flag_stb, flag_code, FC_PULSE);  // see RL21
  wire char_evt  = dev_s2_r.char_stb && !stb_d_r;
  wire running   = (state_r == PBDSC_RUN);
  wire cur_bad   = char_evt && dev_s2_r.par_bad && (ctrl_r.op == OP_READ);
  wire last_char = char_evt && (ctrl_r.count <= CNT_ONE);

  // Parameters are taken from the freshly latched word when both arrive together
  wire pbdsc_ctrl_t eff_ctrl = ctrl_wr ? ctrl_nxt : ctrl_r;

  // Write to a protected tape or reverse space at the tape start is refused
  wire illegal = ((eff_ctrl.op == OP_WRITE) && dev_s2_r.wprot)  // see RL13
              || ((eff_ctrl.op == OP_SPREV) && dev_s2_r.bot);   // see RL13

  // Accumulator fields unpack into the control latch
  // One driver for the whole struct; unit is bus bits 13-15, see RL14
  assign ctrl_nxt = {ctrl_word[CW_UNIT_LO +: 3], ctrl_word[CW_OP_LO +: 3], ctrl_word[CW_CNT_LO +: 8]};  // see RL17

  // Next state: clear wins over a device completion, start restarts from any state
  always_comb begin
    state_nxt   = state_r;
    par_err_nxt = par_err_r;
    ill_nxt     = ill_r;
    if (clear_cmd) begin
      state_nxt = PBDSC_IDLE;                          // see RL6
    end else if (start_cmd) begin
      par_err_nxt = 1'b0;                              // see RL23
      ill_nxt     = illegal;                           // see RL10
      state_nxt   = illegal ? PBDSC_DONE : PBDSC_RUN;  // see RL1, RL5, RL12
    end else if (running) begin
      if (cur_bad) begin
        par_err_nxt = 1'b1;                            // see RL9, RL11
      end
      if (last_char) begin
        state_nxt = PBDSC_DONE;                        // see RL3
      end
    end
  end

  // Remaining count steps down per character while running
  always_comb begin
    ctrl_nxt_r = ctrl_wr ? ctrl_nxt : ctrl_r;
    if (!ctrl_wr && running && char_evt && !clear_cmd && !start_cmd) begin
      ctrl_nxt_r.count = ctrl_r.count - CNT_ONE;       // see RL16
    end
  end

  // State, parameters and error flags
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r   <= PBDSC_IDLE;
      ctrl_r    <= '0;
      par_err_r <= 1'b0;
      ill_r     <= 1'b0;
      pulse_r   <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      ctrl_r    <= ctrl_nxt_r;                         // see RL15
      par_err_r <= par_err_nxt;
      ill_r     <= ill_nxt;
      pulse_r   <= pulse_cmd;
    end
  end

  // Status word assembled combinationally, captured so the read data is a flop
  wire [WORD_W-1:0] status_nxt = WORD_ZERO
    | ({{(WORD_W-1){1'b0}}, par_err_nxt} << ST_PARITY)  // see RL8
    | ({{(WORD_W-1){1'b0}}, ill_nxt} << ST_ILLEGAL)     // see RL8
    | ({{(WORD_W-1){1'b0}}, dev_s2_r.wprot} << ST_WPROT)
    | ({{(WORD_W-1){1'b0}}, dev_s2_r.bot} << ST_BOT)
    | ({{(WORD_W-3){1'b0}}, ctrl_nxt_r.unit} << ST_UNIT_LO)
    | ({{(WORD_W-8){1'b0}}, ctrl_nxt_r.count} << ST_CNT_LO);  // see RL16

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_r <= WORD_ZERO;
    end else begin
      status_r <= status_nxt;                          // see RL7
    end
  end

  // Flag outputs; no data buffer is offered here since data moves by channel
  assign busy        = running;                        // see RL2
  assign done        = (state_r == PBDSC_DONE);
  assign int_req     = done;                           // see RL4
  assign status_word = status_r;
  assign unit_sel    = ctrl_r.unit;
  assign op_sel      = ctrl_r.op;
  assign op_run      = running;                        // see RL18
  assign pulse_out   = pulse_r;

  // Skip test select
  assign skip_true = (test_code == TF_BUSY_SET) ?  busy :  // see RL22
                     (test_code == TF_BUSY_CLR) ? !busy :
                     (test_code == TF_DONE_SET) ?  done : !done;

  // Named sequences for the start and character-count steps
  sequence s_start_legal;
    start_cmd && !illegal;
  endsequence
  sequence s_start_illegal;
    start_cmd && illegal;
  endsequence
  sequence s_char_step;
    running && char_evt && !flag_stb && !ctrl_wr;
  endsequence

  a_start_sets_busy: assert property (@(posedge clk) disable iff (rst) s_start_legal |=> busy && !done) // see RL1
    else $error("start did not set busy");
  a_illegal_done_now: assert property (@(posedge clk) disable iff (rst)
    s_start_illegal |=> done && !busy && status_word[ST_ILLEGAL]) // see RL10
    else $error("illegal start did not set done and illegal");
  a_busy_holds: assert property (@(posedge clk) disable iff (rst)
    busy && !flag_stb && !last_char |=> busy) // see RL2
    else $error("busy dropped mid operation");
  a_complete_flags: assert property (@(posedge clk) disable iff (rst)
    busy && last_char && !flag_stb |=> !busy && done) // see RL3
    else $error("completion flags wrong");
  a_irq_needs_done: assert property (@(posedge clk) disable iff (rst) int_req == done) // see RL4
    else $error("interrupt without done");
  a_clear_idles: assert property (@(posedge clk) disable iff (rst)
    clear_cmd |=> !busy && !done ##1 (!busy && !done) || $past(flag_stb)) // see RL6
    else $error("clear did not idle");
  a_parity_passive: assert property (@(posedge clk) disable iff (rst)
    busy && cur_bad && !flag_stb && !last_char |=> busy && status_word[ST_PARITY]) // see RL11
    else $error("parity error stopped read");
  a_skip_select: assert property (@(posedge clk) disable iff (rst)
    (test_code == TF_DONE_CLR) |-> skip_true == !done) // see RL22
    else $error("skip test wrong");
  a_start_clears_err: assert property (@(posedge clk) disable iff (rst)
    s_start_legal |=> !status_word[ST_PARITY] && !status_word[ST_ILLEGAL]) // see RL23
    else $error("errors not cleared at start");

  // Flag consistency; the two flags never show together
  a_irq_not_idle: assert property (@(posedge clk) disable iff (rst)
    !done |-> !int_req) // see RL4
    else $error("interrupt while done low");
  a_flags_exclusive: assert property (@(posedge clk) disable iff (rst)
    !(busy && done)) // see RL3
    else $error("busy and done together");
  a_run_tracks_busy: assert property (@(posedge clk) disable iff (rst)
    op_run == busy) // see RL18
    else $error("run level differs from busy");
  a_done_holds: assert property (@(posedge clk) disable iff (rst)
    done && !flag_stb |=> done) // see RL3
    else $error("done dropped without command");
  a_idle_holds: assert property (@(posedge clk) disable iff (rst)
    !busy && !done && !flag_stb |=> !busy && !done) // see RL6
    else $error("idle peripheral woke up");
  a_illegal_no_run: assert property (@(posedge clk) disable iff (rst)
    s_start_illegal |=> !op_run) // see RL10
    else $error("refused operation began");
  a_illegal_stable: assert property (@(posedge clk) disable iff (rst)
    !start_cmd |=> $stable(status_word[ST_ILLEGAL])) // see RL12
    else $error("illegal flag moved without start");

  // Pulse is a single registered cycle and leaves the flags alone
  a_pulse_once: assert property (@(posedge clk) disable iff (rst)
    pulse_cmd |=> pulse_out) // see RL21
    else $error("pulse missing");
  a_pulse_quiet: assert property (@(posedge clk) disable iff (rst)
    !pulse_cmd |=> !pulse_out) // see RL21
    else $error("pulse without command");
  a_pulse_no_start: assert property (@(posedge clk) disable iff (rst)
    pulse_cmd && !busy |=> !busy) // see RL21
    else $error("pulse started an operation");

  // Control latch and its read-back through the status word
  a_unit_latch: assert property (@(posedge clk) disable iff (rst)
    ctrl_wr |=> unit_sel == $past(ctrl_word[CW_UNIT_LO +: 3])) // see RL14
    else $error("unit not latched");
  a_op_latch: assert property (@(posedge clk) disable iff (rst)
    ctrl_wr |=> op_sel == $past(ctrl_word[CW_OP_LO +: 3])) // see RL17
    else $error("operation not latched");
  a_count_latch: assert property (@(posedge clk) disable iff (rst)
    ctrl_wr |=> status_word[ST_CNT_LO +: 8] == $past(ctrl_word[CW_CNT_LO +: 8])) // see RL16
    else $error("count not latched");
  a_count_steps: assert property (@(posedge clk) disable iff (rst)
    s_char_step |=> status_word[ST_CNT_LO +: 8] == $past(ctrl_r.count) - CNT_ONE) // see RL16
    else $error("count did not step");
  a_unit_readback: assert property (@(posedge clk) disable iff (rst)
    status_word[ST_UNIT_LO +: 3] == unit_sel) // see RL15
    else $error("unit read back wrong");

  // Device condition bits follow the synchronised lines one cycle late
  a_wprot_status: assert property (@(posedge clk) disable iff (rst)
    status_word[ST_WPROT] == $past(dev_s2_r.wprot)) // see RL8
    else $error("protect bit wrong");
  a_bot_status: assert property (@(posedge clk) disable iff (rst)
    status_word[ST_BOT] == $past(dev_s2_r.bot)) // see RL8
    else $error("tape start bit wrong");
  a_parity_holds: assert property (@(posedge clk) disable iff (rst)
    !flag_stb && !cur_bad |=> $stable(status_word[ST_PARITY])) // see RL9
    else $error("parity flag moved without cause");

  // Remaining skip selections
  a_skip_busy_set: assert property (@(posedge clk) disable iff (rst)
    (test_code == TF_BUSY_SET) |-> skip_true == busy) // see RL22
    else $error("busy set skip wrong");
  a_skip_busy_clr: assert property (@(posedge clk) disable iff (rst)
    (test_code == TF_BUSY_CLR) |-> skip_true == !busy) // see RL22
    else $error("busy clear skip wrong");
  a_skip_done_set: assert property (@(posedge clk) disable iff (rst)
    (test_code == TF_DONE_SET) |-> skip_true == done) // see RL22
    else $error("done set skip wrong");
endmodule : pbdsc_core

// ---- verilog/pbdsc_pkg.sv ----
// Purpose: Shared constants and types for the peripheral busy/done status core
// Assumes: 16-bit I/O words, bit 0 is the most significant bit in bus numbering
// Notes:   Bus bit n maps to vector index 15-n
package pbdsc_pkg;
  localparam int unsigned WORD_W = 16;

  // Flag control field codes
  localparam logic [1:0] FC_NONE  = 2'h0;
  localparam logic [1:0] FC_START = 2'h1;
  localparam logic [1:0] FC_CLEAR = 2'h2;
  localparam logic [1:0] FC_PULSE = 2'h3;

  // Skip test field codes
  localparam logic [1:0] TF_BUSY_SET  = 2'h0;
  localparam logic [1:0] TF_BUSY_CLR  = 2'h1;
  localparam logic [1:0] TF_DONE_SET  = 2'h2;
  localparam logic [1:0] TF_DONE_CLR  = 2'h3;

  // Operation codes carried in the control word (index 15-n for bus bit n)
  localparam logic [2:0] OP_READ   = 3'h0;
  localparam logic [2:0] OP_WRITE  = 3'h1;
  localparam logic [2:0] OP_SPFWD  = 3'h2;
  localparam logic [2:0] OP_SPREV  = 3'h3;

  // Control word fields: unit in bus bits 13-15, op in bus bits 10-12, count in bus bits 0-7
  localparam int unsigned CW_UNIT_LO = 0;
  localparam int unsigned CW_OP_LO   = 3;
  localparam int unsigned CW_CNT_LO  = 8;

  // Status word bit positions (vector index)
  localparam int unsigned ST_PARITY  = 15;
  localparam int unsigned ST_ILLEGAL = 14;
  localparam int unsigned ST_WPROT   = 13;
  localparam int unsigned ST_BOT     = 12;
  localparam int unsigned ST_UNIT_LO = 0;
  localparam int unsigned ST_CNT_LO  = 4;

  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
  localparam logic [7:0]        CNT_ZERO  = 8'h00;
  localparam logic [7:0]        CNT_ONE   = 8'h01;

  // Latched control parameters
  typedef struct packed {
    logic [2:0] unit;
    logic [2:0] op;
    logic [7:0] count;
  } pbdsc_ctrl_t;

  // Attached device condition lines
  typedef struct packed {
    logic wprot;
    logic bot;
    logic char_stb;
    logic par_bad;
  } pbdsc_dev_t;
endpackage : pbdsc_pkg
